// ===== src/tsr_regs.sv
// Temperature result, EEPROM status and configuration registers with conversion control.
// Assumes the converter, limit register and EEPROM port run on I_CLK, so no synchronisers.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps

module tsr_regs #(
	parameter int EE_PROG_CYC = tsr_pkg::EE_PROG_CYC
) (
	input wire logic I_CLK,
	input wire logic I_RESETN,
	input wire logic [4:0] I_ADDR,
	input wire logic [15:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [15:0] O_RDATA,
	input wire logic I_CONV_DONE,
	input wire logic [13:0] I_CONV_DATA,
	input wire logic [15:0] I_HIGH_LIMIT1,
	output logic O_CONV_START,
	output logic O_CONV_ABORT,
	output logic [2:0] O_CONV_RATE,
	output logic O_EE_WRITE,
	output logic [15:0] O_EE_DATA,
	output logic O_IRQ
);

	localparam int CNT_W = $clog2(EE_PROG_CYC + 1);
	// The EEPROM copy keeps only writable bits; flags and one-shot go out as zero
	localparam logic [15:0] EE_MASK = {3'h7, 1'b0, 1'b1, 1'b0, tsr_pkg::CFG_LOW_MASK};

	// ****************************************
	// Register state
	// ****************************************
	tsr_pkg::tsr_cfg_s cfg;
	tsr_pkg::tsr_cfg_s next_cfg;
	logic [13:0] temp_result;
	logic [13:0] next_temp_result;
	logic eeprom_unlock;
	logic next_eeprom_unlock;
	logic busy;
	logic next_busy;
	logic [CNT_W-1:0] prog_cnt;
	logic [CNT_W-1:0] next_prog_cnt;
	logic [2:0] irq_stat;
	logic [2:0] next_irq_stat;
	logic [2:0] irq_en;
	logic [2:0] next_irq_en;
	logic [15:0] next_rdata;
	logic next_ee_write;
	logic [15:0] next_ee_data;
	logic next_irq;

	// ****************************************
	// Conversion state
	// ****************************************
	tsr_pkg::tsr_state_e state;
	tsr_pkg::tsr_state_e next_state;
	logic one_shot_run;
	logic next_one_shot_run;
	logic next_conv_start;
	logic next_conv_abort;

	logic cfg_wr;
	logic temp_wr;
	logic conv_end;
	logic above_limit;
	logic [15:0] cfg_word;
	tsr_pkg::tsr_cfg_s wr_cfg;

	// Configuration and temperature writes are refused while EEPROM programming runs; interrupt writes are not
	assign cfg_wr = I_WR && (I_ADDR == tsr_pkg::ADDR_CFG) && !busy;
	assign temp_wr = I_WR && (I_ADDR == tsr_pkg::ADDR_TEMP) && !busy;
	assign wr_cfg = tsr_pkg::tsr_cfg_s'(I_WDATA);
	// A result that lands in the same cycle as a configuration write belongs to the aborted run
	assign conv_end = (state == tsr_pkg::ST_CONV) && I_CONV_DONE && !cfg_wr;
	assign above_limit = $signed(I_CONV_DATA) > $signed(I_HIGH_LIMIT1[15:2]);
	// One-shot always reads back as zero
	assign cfg_word = {cfg.conv_rate, 1'b0, cfg.shutdown_select, cfg.high_limit1_flag,
		cfg.low};

	// ****************************************
	// Registers and EEPROM program timer
	// ****************************************
	always_comb begin
		next_cfg = cfg;
		next_temp_result = temp_result;
		next_eeprom_unlock = eeprom_unlock;
		next_busy = busy;
		next_prog_cnt = prog_cnt;
		next_ee_write = 1'b0;
		next_ee_data = O_EE_DATA;
		next_irq_en = irq_en;
		next_irq_stat = irq_stat;
		next_rdata = 16'h0000;
		// Clear goes first so that an event of the same cycle sets its bit again: set wins
		if (I_WR && I_ADDR == tsr_pkg::ADDR_IRQ_CLR) begin
			next_irq_stat = irq_stat & ~I_WDATA[2:0];
		end
		if (busy) begin
			if (prog_cnt == '0) begin
				next_busy = 1'b0;
				next_irq_stat[tsr_pkg::IRQ_EE_DONE] = 1'b1;
			end else begin
				next_prog_cnt = prog_cnt - 1'b1;
			end
		end
		if (temp_wr) begin
			next_eeprom_unlock = I_WDATA[tsr_pkg::TEMP_UNLOCK_BIT];
		end
		if (cfg_wr) begin
			next_cfg.conv_rate = wr_cfg.conv_rate;
			next_cfg.shutdown_select = wr_cfg.shutdown_select;
			next_cfg.low = wr_cfg.low & tsr_pkg::CFG_LOW_MASK;
			if (eeprom_unlock) begin
				next_ee_write = 1'b1;
				next_ee_data = I_WDATA & EE_MASK;
				next_busy = 1'b1;
				next_prog_cnt = CNT_W'(EE_PROG_CYC - 1);
			end
		end
		if (conv_end) begin
			next_temp_result = I_CONV_DATA;
			next_cfg.high_limit1_flag = above_limit;
			next_irq_stat[tsr_pkg::IRQ_CONV_DONE] = 1'b1;
			if (above_limit && !cfg.high_limit1_flag) begin
				next_irq_stat[tsr_pkg::IRQ_HIGH_LIMIT] = 1'b1;
			end
		end
		if (I_WR && I_ADDR == tsr_pkg::ADDR_IRQ_EN) begin
			next_irq_en = I_WDATA[2:0];
		end
		if (I_RD) begin
			case (I_ADDR)
				tsr_pkg::ADDR_TEMP: next_rdata = {temp_result, busy, eeprom_unlock};
				tsr_pkg::ADDR_CFG: next_rdata = cfg_word;
				tsr_pkg::ADDR_IRQ_STAT: next_rdata = {13'h0000, irq_stat};
				tsr_pkg::ADDR_IRQ_EN: next_rdata = {13'h0000, irq_en};
				default: next_rdata = 16'h0000;
			endcase
		end
		next_irq = |(next_irq_stat & next_irq_en);
	end

	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			cfg <= tsr_pkg::tsr_cfg_s'(tsr_pkg::CFG_RESET);
			temp_result <= 14'h0000;
			eeprom_unlock <= 1'b0;
			busy <= 1'b0;
			prog_cnt <= '0;
			irq_stat <= 3'h0;
			irq_en <= 3'h0;
			O_RDATA <= 16'h0000;
			O_EE_WRITE <= 1'b0;
			O_EE_DATA <= 16'h0000;
			O_IRQ <= 1'b0;
		end else begin
			cfg <= next_cfg;
			temp_result <= next_temp_result;
			eeprom_unlock <= next_eeprom_unlock;
			busy <= next_busy;
			prog_cnt <= next_prog_cnt;
			irq_stat <= next_irq_stat;
			irq_en <= next_irq_en;
			O_RDATA <= next_rdata;
			O_EE_WRITE <= next_ee_write;
			O_EE_DATA <= next_ee_data;
			O_IRQ <= next_irq;
		end
	end

	// ****************************************
	// Conversion sequencing
	// ****************************************
	always_comb begin
		next_state = state;
		next_one_shot_run = one_shot_run;
		next_conv_start = 1'b0;
		next_conv_abort = 1'b0;
		if (cfg_wr) begin
			next_conv_abort = (state == tsr_pkg::ST_CONV);
			// One-shot counts only in shutdown; in continuous mode it is just a restart
			if (!wr_cfg.shutdown_select || wr_cfg.one_shot_trigger) begin
				next_conv_start = 1'b1;
				next_state = tsr_pkg::ST_CONV;
				next_one_shot_run = wr_cfg.shutdown_select;
			end else begin
				next_state = tsr_pkg::ST_IDLE;
			end
		end else begin
			case (state)
				tsr_pkg::ST_IDLE: begin
					if (!cfg.shutdown_select) begin
						next_conv_start = 1'b1;
						next_state = tsr_pkg::ST_CONV;
						next_one_shot_run = 1'b0;
					end
				end
				tsr_pkg::ST_CONV: begin
					if (I_CONV_DONE) begin
						if (one_shot_run || cfg.shutdown_select) begin
							next_state = tsr_pkg::ST_IDLE;
						end else begin
							next_conv_start = 1'b1;
						end
					end
				end
				default: next_state = tsr_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			state <= tsr_pkg::ST_IDLE;
			one_shot_run <= 1'b0;
			O_CONV_START <= 1'b0;
			O_CONV_ABORT <= 1'b0;
			O_CONV_RATE <= tsr_pkg::CFG_RESET[15:13];
		end else begin
			state <= next_state;
			one_shot_run <= next_one_shot_run;
			O_CONV_START <= next_conv_start;
			O_CONV_ABORT <= next_conv_abort;
			O_CONV_RATE <= next_cfg.conv_rate;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RESETN);

	a_write_aborts_conv: assert property (
		cfg_wr && state == tsr_pkg::ST_CONV |=> O_CONV_ABORT)
		else $error("configuration write did not abort the running conversion");
	a_rate_restart: assert property (
		cfg_wr && !I_WDATA[11] |=> O_CONV_START && O_CONV_RATE == $past(I_WDATA[15:13]))
		else $error("continuous write did not restart at the new rate");
	a_locked_no_prog: assert property (
		cfg_wr && !eeprom_unlock |=> !O_EE_WRITE && !busy)
		else $error("locked configuration write reached the EEPROM");
	a_unlocked_prog: assert property (
		cfg_wr && eeprom_unlock |=> O_EE_WRITE ##1 busy [*8])
		else $error("unlocked configuration write did not program the EEPROM");
	// The high flag may still move with a conversion result, so only written fields are held
	a_busy_refuses_write: assert property (
		busy && I_WR && I_ADDR == tsr_pkg::ADDR_CFG
			|=> $stable({cfg.conv_rate, cfg.shutdown_select, cfg.low}) && !O_CONV_ABORT)
		else $error("configuration changed during EEPROM programming");
	a_busy_keeps_unlock: assert property (
		busy && I_WR && I_ADDR == tsr_pkg::ADDR_TEMP |=> $stable(eeprom_unlock))
		else $error("unlock flag changed during EEPROM programming");
	a_unlock_write: assert property (
		temp_wr |=> eeprom_unlock == $past(I_WDATA[tsr_pkg::TEMP_UNLOCK_BIT]))
		else $error("unlock flag did not take the written value");
	a_shutdown_idle: assert property (
		cfg_wr && I_WDATA[11] && !I_WDATA[12] |=> state == tsr_pkg::ST_IDLE && !O_CONV_START)
		else $error("shutdown write did not stop conversions at once");
	a_os_reads_zero: assert property (
		I_RD && I_ADDR == tsr_pkg::ADDR_CFG |=> !O_RDATA[12])
		else $error("one-shot bit read back as one");
	a_busy_bit_read: assert property (
		I_RD && I_ADDR == tsr_pkg::ADDR_TEMP |=> O_RDATA[1] == $past(busy))
		else $error("busy bit does not follow EEPROM state");
	a_result_update: assert property (
		conv_end |=> temp_result == $past(I_CONV_DATA)
			&& cfg.high_limit1_flag == $past(above_limit))
		else $error("conversion result or high flag not updated");
	// A host write right after the result may legally start something new in the second cycle
	a_oneshot_return: assert property (
		conv_end && one_shot_run |=> (state == tsr_pkg::ST_IDLE && !O_CONV_START)
			##1 ((state == tsr_pkg::ST_IDLE && !O_CONV_START) || $past(cfg_wr)))
		else $error("one-shot conversion did not return to shutdown");

	c_oneshot: cover property (cfg_wr && I_WDATA[12] && I_WDATA[11] ##[1:50] conv_end);
	c_ee_program: cover property (O_EE_WRITE ##[1:100] !busy);
	c_abort: cover property (O_CONV_ABORT ##1 state == tsr_pkg::ST_CONV);
	c_refused_write: cover property (busy && I_WR && I_ADDR == tsr_pkg::ADDR_TEMP);

endmodule // tsr_regs

// ===== src/tsr_pkg.sv
// Package of the temperature sensor status and configuration register block.
// Assumes one 100 MHz device clock shared by the register port and the converter.
package tsr_pkg;

	// ****************************************
	// Register pointers
	// ****************************************
	localparam int ADDR_W = 5;
	localparam logic [4:0] ADDR_TEMP = 5'h00;
	localparam logic [4:0] ADDR_CFG = 5'h01;
	localparam logic [4:0] ADDR_IRQ_STAT = 5'h10;
	localparam logic [4:0] ADDR_IRQ_CLR = 5'h11;
	localparam logic [4:0] ADDR_IRQ_EN = 5'h12;

	// ****************************************
	// Field layout and reset values
	// ****************************************
	localparam int TEMP_W = 14;
	localparam int TEMP_LSB = 2;
	localparam int TEMP_BUSY_BIT = 1;
	localparam int TEMP_UNLOCK_BIT = 0;
	localparam logic [15:0] CFG_RESET = 16'hA000;
	// Writable low configuration bits that this block only stores
	localparam logic [9:0] CFG_LOW_MASK = 10'h198;
	localparam int IRQ_W = 3;
	localparam int IRQ_CONV_DONE = 0;
	localparam int IRQ_HIGH_LIMIT = 1;
	localparam int IRQ_EE_DONE = 2;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int EE_PROG_NS = 16_000_000;
	localparam int EE_PROG_CYC = EE_PROG_NS / CLK_PERIOD_NS;

	typedef struct packed {
		logic [2:0] conv_rate;
		logic one_shot_trigger;
		logic shutdown_select;
		logic high_limit1_flag;
		logic [9:0] low;
	} tsr_cfg_s;

	typedef enum {ST_IDLE, ST_CONV} tsr_state_e;

endpackage

// ===== bench/tsr_conv_model.sv
// Behavioural converter that answers conversion starts of the register block.
// Assumes start and abort are one-cycle pulses on the same clock.
`timescale 1ns/1ps

module tsr_conv_model #(
	parameter int LAT = 30
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_start,
	input wire logic i_abort,
	input wire logic [13:0] i_value,
	output logic o_done,
	output logic [13:0] o_data
);
	// ****************************************
	// Conversion timer
	// ****************************************
	int cnt;
	logic [13:0] last;
	// Data lines alternate between the last result and its inverse outside the done pulse, so a one-cycle-late sample fails
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt <= 0;
			o_done <= 1'b0;
			o_data <= 14'h0000;
			last <= 14'h0000;
		end else begin
			o_done <= 1'b0;
			o_data <= ~last;
			last <= ~last;
			if (i_start) begin
				cnt <= LAT;
			end else if (i_abort) begin
				cnt <= 0;
			end else if (cnt == 1) begin
				o_done <= 1'b1;
				o_data <= i_value;
				last <= i_value;
				cnt <= 0;
			end else if (cnt > 1) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule // tsr_conv_model

// ===== bench/test_tsr_regs.sv
// Self-checking bench of the temperature status and configuration registers.
// Assumes the converter model above; programming time shortened to EE cycles.
`timescale 1ns/1ps

module test_tsr_regs;
	// ****************************************
	// Signals and model state
	// ****************************************
	localparam int EE = 20;
	logic I_CLK = 0, I_RESETN = 0, I_WR = 0, I_RD = 0, I_CONV_DONE, O_IRQ;
	logic O_CONV_START, O_CONV_ABORT, O_EE_WRITE;
	logic [4:0] I_ADDR = 5'h00;
	logic [15:0] I_WDATA = 16'h0000, I_HIGH_LIMIT1 = 16'h0000, O_RDATA, O_EE_DATA, d;
	logic [13:0] conv_value = 14'h0000, I_CONV_DATA;
	logic [2:0] O_CONV_RATE;
	logic [31:0] seed = 32'h9C58_D6A7;
	int n_errors = 0, checked = 0, cyc = 0, n_start = 0, n_abort = 0, n_ee = 0;
	int s0, s1, k, fh = 0, m_cfg = 'hA000, m_temp = 0;

	tsr_regs #(.EE_PROG_CYC(EE)) tsr_regs_inst (.I_CLK(I_CLK), .I_RESETN(I_RESETN),
		.I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
		.I_CONV_DONE(I_CONV_DONE), .I_CONV_DATA(I_CONV_DATA), .I_HIGH_LIMIT1(I_HIGH_LIMIT1),
		.O_CONV_START(O_CONV_START), .O_CONV_ABORT(O_CONV_ABORT), .O_CONV_RATE(O_CONV_RATE),
		.O_EE_WRITE(O_EE_WRITE), .O_EE_DATA(O_EE_DATA), .O_IRQ(O_IRQ));
	tsr_conv_model tsr_conv_model_inst (.i_clk(I_CLK), .i_resetn(I_RESETN),
		.i_start(O_CONV_START), .i_abort(O_CONV_ABORT), .i_value(conv_value),
		.o_done(I_CONV_DONE), .o_data(I_CONV_DATA));

	initial forever #5 I_CLK = ~I_CLK;
	always @(posedge I_CLK) begin
		cyc++;
		n_start += (O_CONV_START === 1'b1);
		n_abort += (O_CONV_ABORT === 1'b1);
		n_ee += (O_EE_WRITE === 1'b1);
		if (cyc == 20000) begin
			n_errors++;
			test_done();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		@(posedge I_CLK);
		I_WR <= 1'b1;
		I_ADDR <= a;
		I_WDATA <= v;
		@(posedge I_CLK);
		I_WR <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a);
		@(posedge I_CLK);
		I_RD <= 1'b1;
		I_ADDR <= a;
		@(posedge I_CLK);
		I_RD <= 1'b0;
		#1 d = O_RDATA;
	endtask
	task automatic wstart();
		for (int i = 0; i < 200 && O_CONV_START !== 1'b1; i++) @(posedge I_CLK);
		@(posedge I_CLK);
	endtask
	// Waits for one result, then updates the model and compares both words
	task automatic conv();
		for (int i = 0; i < 200 && I_CONV_DONE !== 1'b1; i++) @(posedge I_CLK);
		repeat (2) @(posedge I_CLK);
		fh = $signed(conv_value) > $signed(I_HIGH_LIMIT1[15:2]);
		m_temp = {conv_value, 2'b00};
		m_cfg = (m_cfg & 'hFBFF) | (fh << 10);
		rd(ADDR0());
		chk("temp", m_temp, d);
		rd(5'h01);
		chk("cfg", m_cfg, d);
	endtask
	function automatic logic [4:0] ADDR0();
		return 5'h00;
	endfunction
	task automatic test_done();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		repeat (10) @(posedge I_CLK);
		I_RESETN <= 1'b1;
		rd(5'h00);
		chk("temp", 16'h0000, d);
		rd(5'h01);
		chk("cfg", 16'hA000, d);
		chk("rate", 16'h0005, 16'(O_CONV_RATE));
		for (k = 0; k < 3; k++) begin
			seed = lfsr(seed);
			conv_value <= seed[13:0];
			I_HIGH_LIMIT1 <= k == 0 ? 16'h7FFF : k == 1 ? 16'h8000 : seed[31:16];
			wstart();
			conv();
		end
		wstart();
		s0 = n_abort;
		s1 = n_start;
		seed = lfsr(seed);
		wr(5'h01, 16'h7000 | (seed[15:0] & 16'h0198));
		m_cfg = (16'h6000 | (seed[15:0] & 16'h0198)) | (fh << 10);
		repeat (2) @(posedge I_CLK);
		chk("abort", 16'(s0 + 1), 16'(n_abort));
		chk("start", 16'(s1 + 1), 16'(n_start));
		chk("rate", 16'h0003, 16'(O_CONV_RATE));
		rd(5'h01);
		chk("cfg", m_cfg, d);
		wstart();
		s0 = n_abort;
		wr(5'h01, 16'h0800);
		m_cfg = 'h0800 | (fh << 10);
		s1 = n_start;
		repeat (100) @(posedge I_CLK);
		chk("abort", 16'(s0 + 1), 16'(n_abort));
		chk("start", 16'(s1), 16'(n_start));
		seed = lfsr(seed);
		conv_value <= seed[13:0];
		wr(5'h01, 16'h1800);
		conv();
		repeat (100) @(posedge I_CLK);
		chk("start", 16'(s1 + 1), 16'(n_start));
		wr(5'h00, 16'h0001);
		rd(5'h00);
		chk("temp", 16'(m_temp | 1), d);
		s0 = n_ee;
		wr(5'h01, 16'h0D98);
		m_cfg = 'h0998 | (fh << 10);
		rd(5'h00);
		chk("temp", 16'(m_temp | 3), d);
		chk("ee_write", 16'(s0 + 1), 16'(n_ee));
		chk("ee_data", 16'h0998, O_EE_DATA);
		wr(5'h01, 16'h0000);
		rd(5'h01);
		chk("cfg", m_cfg, d);
		wr(5'h00, 16'h0000);
		rd(5'h00);
		chk("temp", 16'(m_temp | 3), d);
		repeat (EE + 5) @(posedge I_CLK);
		rd(5'h00);
		chk("temp", 16'(m_temp | 1), d);
		rd(5'h10);
		chk("ee_done", 16'h0004, d & 16'h0004);
		wr(5'h00, 16'h0000);
		wr(5'h01, 16'h0810);
		repeat (2) @(posedge I_CLK);
		chk("ee_write", 16'(s0 + 1), 16'(n_ee));
		rd(5'h01);
		chk("cfg", 16'(16'h0810 | (fh << 10)), d);
		wr(5'h12, 16'h0004);
		repeat (2) @(posedge I_CLK);
		chk("irq", 16'h0001, 16'(O_IRQ));
		wr(5'h11, 16'h0004);
		repeat (2) @(posedge I_CLK);
		chk("irq", 16'h0000, 16'(O_IRQ));
		rd(5'h1F);
		chk("unmapped", 16'h0000, d);
		test_done();
	end
endmodule // test_tsr_regs
